// ===== src/rwc_reset_control.sv
// rwc_reset_control: reset combiner, start-up stretch, watchdog control, AXI4-Lite registers
//
// The address map and the AXI4-Lite register port were decided locally.
module rwc_reset_control
  import rwc_pkg::*;
#(
  parameter int DELAY_CYC0 = START_CYC0,
  parameter int DELAY_CYC1 = START_CYC1,
  parameter int DELAY_CYC2 = START_CYC2,
  parameter int DELAY_CYC3 = START_CYC3,
  parameter int WDOG_TICK  = WDOG_DIV
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire rwc_fuse_t         fuse,
  input  wire rwc_supply_t       supply,
  input  wire logic              pinResetEnable,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   ioResetN,
  output logic                   coreResetN,
  output logic                   vectorStart,
  output logic                   refEnable,
  output logic                   watchdogIrq,
  output logic                   watchdogWake
);

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  localparam int BRN_W = $clog2(BROWNOUT_MIN_CYC + 1);

  logic             brownoutEnable;
  logic             pinLow;
  logic             rawRstN;
  logic [BRN_W-1:0] brnCnt_reg;
  logic             brownoutRst_reg;
  logic             wdogPulse_reg;
  logic             syncStage_reg;

  assign brownoutEnable = (fuse.brownoutLevel != BROWNOUT_OFF);
  assign pinLow         = pinResetEnable && !supply.resetPinN;
  // nrst, power-on and pin act on the flops directly; brown-out and watchdog requests are registered first
  assign rawRstN = nrst && !supply.porActive && !pinLow
                   && !brownoutRst_reg && !wdogPulse_reg;

  // short dips are filtered before they reach the reset tree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      brnCnt_reg      <= '0;
      brownoutRst_reg <= 1'b0;
    end else if (brownoutEnable && supply.brownoutLow) begin
      if (brnCnt_reg != BRN_W'(BROWNOUT_MIN_CYC)) begin
        brnCnt_reg <= brnCnt_reg + 1'b1;
      end
      brownoutRst_reg <= (brnCnt_reg >= BRN_W'(BROWNOUT_MIN_CYC - 1));
    end else begin
      brnCnt_reg      <= '0;
      brownoutRst_reg <= 1'b0;
    end
  end

  // asynchronous entry, two-flop synchronous release
  always_ff @(posedge mclk or negedge rawRstN) begin
    if (!rawRstN) begin
      syncStage_reg <= 1'b0;
      ioResetN      <= 1'b0;
    end else begin
      syncStage_reg <= 1'b1;
      ioResetN      <= syncStage_reg;
    end
  end

  // ----------------------------------------------------------------
  // start-up delay
  // ----------------------------------------------------------------
  rwc_state_t         state_reg;
  rwc_state_t         state_next;
  logic [DELAY_W-1:0] delay_reg;
  logic [DELAY_W-1:0] delayLoad;
  logic [DELAY_W-1:0] delayBase;
  logic [DELAY_W-1:0] warmCyc;

  assign warmCyc   = (fuse.clockSource == CKSRC_EXTERNAL) ? '0 : DELAY_W'(OSC_WARM_CYC);
  assign delayBase = (fuse.startupTime == 2'h0) ? DELAY_W'(DELAY_CYC0) :
                     (fuse.startupTime == 2'h1) ? DELAY_W'(DELAY_CYC1) :
                     (fuse.startupTime == 2'h2) ? DELAY_W'(DELAY_CYC2) :
                                                  DELAY_W'(DELAY_CYC3);
  assign delayLoad = delayBase + warmCyc;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HOLD:    state_next = ST_STRETCH;
      ST_STRETCH: if (delay_reg == '0) state_next = ST_RUN;
      ST_RUN:     state_next = ST_RUN;
      default:    state_next = ST_HOLD;
    endcase
  end

  always_ff @(posedge mclk or negedge ioResetN) begin
    if (!ioResetN) begin
      state_reg   <= ST_HOLD;
      delay_reg   <= '0;
      coreResetN  <= 1'b0;
      vectorStart <= 1'b0;
    end else begin
      state_reg   <= state_next;
      delay_reg   <= (state_reg == ST_HOLD) ? delayLoad :
                     (delay_reg != '0) ? delay_reg - 1'b1 : '0;
      coreResetN  <= (state_next == ST_RUN);
      vectorStart <= (state_next == ST_RUN) && (state_reg != ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]       wData_reg;
  logic [3:0]        wStrb_reg;
  logic              awFull_reg;
  logic              wFull_reg;
  logic              wrFire;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;
  logic              wrLane0;
  logic              wrStatus;
  logic              wrWdog;
  logic              wrRestart;
  logic              wrAnalog;
  logic              wrMapped;
  logic              rdMapped;
  logic [31:0]       rdMux;

  assign wrFire    = awFull_reg && wFull_reg && !bvalid;
  assign wrAddr    = {awAddr_reg[ADDR_W-1:2], 2'b00};
  assign rdAddr    = {araddr[ADDR_W-1:2], 2'b00};
  assign wrLane0   = wrFire && wStrb_reg[0];
  assign wrStatus  = wrLane0 && (wrAddr == ADDR_STATUS);
  assign wrWdog    = wrLane0 && (wrAddr == ADDR_WDOG);
  assign wrRestart = wrFire && (wrAddr == ADDR_RESTART);
  assign wrAnalog  = wrLane0 && (wrAddr == ADDR_ANALOG);
  assign wrMapped  = (wrAddr == ADDR_STATUS) || (wrAddr == ADDR_WDOG)
                     || (wrAddr == ADDR_RESTART) || (wrAddr == ADDR_ANALOG);
  assign rdMapped  = (rdAddr == ADDR_STATUS) || (rdAddr == ADDR_WDOG)
                     || (rdAddr == ADDR_RESTART) || (rdAddr == ADDR_ANALOG);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      awFull_reg <= 1'b0;
      wFull_reg  <= 1'b0;
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awFull_reg <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wFull_reg <= 1'b1;
        wready    <= 1'b0;
      end
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid     <= 1'b0;
        awFull_reg <= 1'b0;
        wFull_reg  <= 1'b0;
        awready    <= 1'b1;
        wready     <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  // these live on the external reset only, so they survive the chip reset they record
  logic [STAT_N-1:0] statFlag_reg;
  logic [STAT_N-1:0] statSet;
  logic [STAT_N-1:0] statClr;

  assign statSet = {wdogPulse_reg, brownoutRst_reg, pinLow, supply.porActive};

  genvar gi;
  generate
    for (gi = 0; gi < STAT_N; gi++) begin : g_flag
      // power-on wipes the other causes; software clears by writing zero
      assign statClr[gi] = (wrStatus && !wData_reg[gi])
                           || ((gi != STAT_POR) && supply.porActive);
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          statFlag_reg[gi] <= 1'b0;
        end else begin
          statFlag_reg[gi] <= statSet[gi] || (statFlag_reg[gi] && !statClr[gi]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // watchdog control
  // ----------------------------------------------------------------
  logic       resetEn_reg;
  logic       irqEn_reg;
  logic       irqFlag_reg;
  logic [3:0] prescale_reg;
  logic [2:0] changeCnt_reg;
  logic       changeActive;
  logic       effResetEn;
  logic       running;
  logic       expiredRaw;
  logic       expiredSync_reg;
  logic       irqSet;
  logic       irqEnHwClr;
  logic       levelTwo;
  logic       changeArm;

  assign levelTwo     = fuse.watchdogAlwaysOn;
  assign changeActive = (changeCnt_reg != 3'h0);
  assign changeArm    = wData_reg[WD_CHANGE_EN] && wData_reg[WD_RESET_EN];
  assign effResetEn   = resetEn_reg || levelTwo
                        || (!levelTwo && statFlag_reg[STAT_WDOG]);
  assign running      = effResetEn || irqEn_reg;
  assign irqSet       = expiredSync_reg && irqEn_reg;
  assign irqEnHwClr   = irqSet && effResetEn;

  rwc_watchdog_counter #(.TICK_CYC(WDOG_TICK)) u_counter (
    .mclk     (mclk),
    .rstN     (ioResetN),
    .running  (running),
    .restart  (wrRestart),
    .prescale (prescale_reg),
    .expired  (expiredRaw)
  );

  always_ff @(posedge mclk or negedge ioResetN) begin
    if (!ioResetN) begin
      expiredSync_reg <= 1'b0;
      changeCnt_reg   <= 3'h0;
      resetEn_reg     <= 1'b0;
      prescale_reg    <= 4'h0;
      irqEn_reg       <= 1'b0;
      irqFlag_reg     <= 1'b0;
    end else begin
      expiredSync_reg <= expiredRaw;
      if (wrWdog) begin
        changeCnt_reg <= changeArm ? CE_HOLD_CYC : 3'h0;
      end else if (changeActive) begin
        changeCnt_reg <= changeCnt_reg - 1'b1;
      end
      // clearing the enable needs the change window; level two keeps it forced on
      if (wrWdog && wData_reg[WD_RESET_EN]) begin
        resetEn_reg <= 1'b1;
      end else if (wrWdog && changeActive) begin
        resetEn_reg <= 1'b0;
      end
      if (wrWdog && (!levelTwo || changeActive)) begin
        prescale_reg <= {wData_reg[WD_P3], wData_reg[2:0]};
      end
      if (irqEnHwClr) begin
        irqEn_reg <= 1'b0;
      end else if (wrWdog) begin
        irqEn_reg <= wData_reg[WD_IRQ_EN];
      end
      irqFlag_reg <= irqSet || (irqFlag_reg && !(wrWdog && wData_reg[WD_IRQ_FLAG]));
    end
  end

  // expiry in reset mode gives a single clock pulse; release of it starts the stretch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdogPulse_reg <= 1'b0;
    end else begin
      wdogPulse_reg <= expiredSync_reg && !irqEn_reg && effResetEn;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      watchdogIrq  <= 1'b0;
      watchdogWake <= 1'b0;
    end else begin
      // the enable is cleared by the same expiry in combined mode, yet the interrupt must still run
      watchdogIrq  <= irqFlag_reg && (irqEn_reg || effResetEn) && ioResetN;
      watchdogWake <= irqSet;
    end
  end

  // ----------------------------------------------------------------
  // analog enables and voltage reference
  // ----------------------------------------------------------------
  logic cmpBandgap_reg;
  logic adcEn_reg;

  always_ff @(posedge mclk or negedge ioResetN) begin
    if (!ioResetN) begin
      cmpBandgap_reg <= 1'b0;
      adcEn_reg      <= 1'b0;
    end else if (wrAnalog) begin
      cmpBandgap_reg <= wData_reg[AN_CMP_BANDGAP];
      adcEn_reg      <= wData_reg[AN_ADC_EN];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refEnable <= 1'b0;
    end else begin
      refEnable <= brownoutEnable || cmpBandgap_reg || adcEn_reg;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rdStatus;
  logic [31:0] rdWdog;
  logic [31:0] rdAnalog;

  assign rdStatus = {28'h0, statFlag_reg};
  assign rdWdog   = {24'h0, irqFlag_reg, irqEn_reg, prescale_reg[3], changeActive,
                     effResetEn, prescale_reg[2:0]};
  assign rdAnalog = {23'h0, refEnable, 6'h0, adcEn_reg, cmpBandgap_reg};
  assign rdMux    = (rdAddr == ADDR_STATUS) ? rdStatus :
                    (rdAddr == ADDR_WDOG)   ? rdWdog   :
                    (rdAddr == ADDR_ANALOG) ? rdAnalog : 32'h0;

endmodule : rwc_reset_control

// ===== src/rwc_pkg.sv
// rwc_pkg: constants and types for the reset and watchdog control block
// Function
// - while reset holds, I/O registers take initial values; execution restarts at vector.
// - any asserting reset source returns I/O to initial state asynchronously, no clock; here brown-out and watchdog requests are registered first.
// - after all sources go inactive, internal reset stretches by fuse-selected delay.
// - chip reset is the OR of power-on, pin, watchdog and brown-out requests.
// - enabled pin reset acts on low level beyond minimum width; driver holds it.
// - pin returning high starts the delay counter; release after the time-out.
// - power-on detector holds reset below level, delays release, reasserts at once.
// - enabled brown-out asserts reset at once; recovery starts the delay counter.
// - brown-out indications shorter than the minimum detection time are ignored.
// - watchdog reset pulse lasts one system clock; delay starts at its trailing edge.
// - watchdog counter runs from a dedicated 128 kHz time base; here it is mclk divided by WDOG_DIV.
// - watchdog counter clears on restart, on disable and on chip reset.
// - ten selectable time-out periods pick watchdog oscillator cycles before expiry.
// - expiry without restart in reset mode resets and resumes from the vector.
// - expiry may raise an interrupt instead of reset, able to wake power-down.
// - fuse picks safety level: level 1 free period, level 2 locked enable.
// - voltage reference enabled only by brown-out, comparator bandgap select, or converter.
// - change-enable bit clears itself four system clocks after being written one.
// - interrupt mode overrides reset; with reset enable set, expiry clears interrupt enable.
// - sticky reset cause flags; level 1 watchdog flag forces watchdog enable on.
package rwc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int WDOG_OSC_HZ       = 128_000;
  localparam int WDOG_DIV          = CLK_HZ / WDOG_OSC_HZ;
  localparam int BROWNOUT_MIN_NS   = 2000;
  localparam int BROWNOUT_MIN_CYC  = (BROWNOUT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int START_US0         = 4;
  localparam int START_US1         = 4100;
  localparam int START_US2         = 65000;
  localparam int START_US3         = 65000;
  localparam int START_CYC0        = START_US0 * (CLK_HZ / 1_000_000);
  localparam int START_CYC1        = START_US1 * (CLK_HZ / 1_000_000);
  localparam int START_CYC2        = START_US2 * (CLK_HZ / 1_000_000);
  localparam int START_CYC3        = START_US3 * (CLK_HZ / 1_000_000);
  localparam int OSC_WARM_US       = 64;
  localparam int OSC_WARM_CYC      = OSC_WARM_US * (CLK_HZ / 1_000_000);
  localparam int DELAY_W           = 24;
  localparam logic [2:0] CE_HOLD_CYC = 3'h4;

  // ----------------------------------------------------------------
  // watchdog counter shape
  // ----------------------------------------------------------------
  localparam int WDOG_CNT_W        = 20;
  localparam int WDOG_BASE_LOG2    = 11;
  localparam logic [3:0] WDOG_MAX_SEL = 4'h9;
  localparam int DIV_W             = 8;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W                 = 8;
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_WDOG      = 8'h04;
  localparam logic [7:0] ADDR_RESTART   = 8'h08;
  localparam logic [7:0] ADDR_ANALOG    = 8'h0C;
  localparam int STAT_POR               = 0;
  localparam int STAT_EXT               = 1;
  localparam int STAT_BROWNOUT          = 2;
  localparam int STAT_WDOG              = 3;
  localparam int STAT_N                 = 4;
  localparam int WD_IRQ_FLAG            = 7;
  localparam int WD_IRQ_EN              = 6;
  localparam int WD_P3                  = 5;
  localparam int WD_CHANGE_EN           = 4;
  localparam int WD_RESET_EN            = 3;
  localparam int AN_CMP_BANDGAP         = 0;
  localparam int AN_ADC_EN              = 1;
  localparam int AN_REF_ON              = 8;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
  localparam logic [2:0] BROWNOUT_OFF   = 3'h7;
  localparam logic [3:0] CKSRC_EXTERNAL = 4'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] startupTime;
    logic [3:0] clockSource;
    logic [2:0] brownoutLevel;
    logic       watchdogAlwaysOn;
  } rwc_fuse_t;

  typedef struct packed {
    logic porActive;
    logic brownoutLow;
    logic resetPinN;
  } rwc_supply_t;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN     = 2'b11
  } rwc_state_t;

endpackage : rwc_pkg

// ===== src/rwc_watchdog_counter.sv
// rwc_watchdog_counter: watchdog time base and prescaled expiry counter
module rwc_watchdog_counter
  import rwc_pkg::*;
#(
  parameter int TICK_CYC = WDOG_DIV
) (
  input  wire logic       mclk,
  input  wire logic       rstN,
  input  wire logic       running,
  input  wire logic       restart,
  input  wire logic [3:0] prescale,
  output logic            expired
);

  logic [DIV_W-1:0]      divCnt_reg;
  logic [WDOG_CNT_W-1:0] count_reg;
  logic                  oscTick;
  logic [3:0]            selClamp;
  logic [WDOG_CNT_W-1:0] limit;
  logic                  atLimit;

  assign oscTick  = (divCnt_reg == DIV_W'(TICK_CYC - 1));
  // reserved select codes fall back to the longest period
  assign selClamp = (prescale > WDOG_MAX_SEL) ? WDOG_MAX_SEL : prescale;
  assign limit    = ~({WDOG_CNT_W{1'b1}} << (WDOG_BASE_LOG2 + int'(selClamp)));
  assign atLimit  = oscTick && (count_reg == limit);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= oscTick ? '0 : divCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      count_reg <= '0;
      expired   <= 1'b0;
    end else begin
      expired <= running && !restart && atLimit;
      if (!running || restart || atLimit) begin
        count_reg <= '0;
      end else if (oscTick) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

endmodule : rwc_watchdog_counter

// ===== dv/rwc_properties.sv
// rwc_properties: port-level checks for the reset and watchdog controller
module rwc_properties
  import rwc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire rwc_fuse_t   fuse,
  input wire rwc_supply_t supply,
  input wire logic        pinResetEnable,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        ioResetN,
  input wire logic        coreResetN,
  input wire logic        vectorStart,
  input wire logic        refEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_por_holds: assert property (supply.porActive |-> !ioResetN)
    else $error("power-on did not hold io reset");
  a_pin_holds: assert property (pinResetEnable && !supply.resetPinN |-> !ioResetN)
    else $error("pin low did not hold io reset");
  a_core_follows: assert property (!ioResetN |-> !coreResetN)
    else $error("core left reset while io reset held");
  a_vector_edge: assert property (vectorStart |-> coreResetN && !$past(coreResetN))
    else $error("vector pulse not at core release");
  a_core_sync: assert property ($rose(coreResetN) |-> $past(ioResetN) && $past(ioResetN, 2))
    else $error("core released without stretch");
  a_ref_brownout: assert property (fuse.brownoutLevel != BROWNOUT_OFF |=> refEnable)
    else $error("reference off while brown-out enabled");
  a_brown_filter: assert property (fuse.brownoutLevel != BROWNOUT_OFF && ioResetN
    && $rose(supply.brownoutLow) && supply.resetPinN && !supply.porActive |=> ioResetN [*8])
    else $error("short brown-out caused reset");
  a_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held after handshake");
  a_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held after handshake");
endmodule : rwc_properties

bind rwc_reset_control rwc_properties i_rwc_properties (.mclk, .nrst, .fuse, .supply,
  .pinResetEnable, .bvalid, .bready, .rvalid, .rready, .ioResetN, .coreResetN,
  .vectorStart, .refEnable);

// ===== dv/rwc_supply_model.sv
// rwc_supply_model: reset pin driver and supply comparators facing the controller
module rwc_supply_model
  import rwc_pkg::*;
#(
  parameter int PIN_MIN_CYC = 6
) (
  input  wire logic   mclk,
  input  wire logic   porReq,
  input  wire logic   pinReq,
  input  wire logic   brownReq,
  output rwc_supply_t supply
);
  timeunit 1ns;
  timeprecision 1ps;
  int pinCnt = 0;
  // the driver never lets a pin pulse end before the minimum width
  always @(posedge mclk) pinCnt <= pinReq ? PIN_MIN_CYC : (pinCnt > 0 ? pinCnt - 1 : 0);
  assign supply.resetPinN   = !(pinReq || pinCnt > 0);
  assign supply.porActive   = porReq;
  assign supply.brownoutLow = brownReq;
endmodule : rwc_supply_model

// ===== dv/tb.sv
// tb: self-checking bench for the reset and watchdog controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rwc_pkg::*;
  localparam int DLY[4] = '{8, 12, 16, 20};
  logic        mclk = 0, nrst = 0, pinResetEnable = 1, porReq = 0, pinReq = 0, brownReq = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, ioResetN, coreResetN;
  logic        vectorStart, refEnable, watchdogIrq, watchdogWake;
  rwc_fuse_t   fuse = '{2'h0, 4'h0, 3'h3, 1'b0};
  rwc_supply_t supply;
  int          errCount = 0, testsRun = 0, cycles = 0;

  rwc_reset_control #(.DELAY_CYC0(8), .DELAY_CYC1(12), .DELAY_CYC2(16), .DELAY_CYC3(20),
    .WDOG_TICK(1)) i_rwc_reset_control (.*);
  rwc_supply_model i_rwc_supply_model (.*);

  initial forever #20 mclk = ~mclk;

  task automatic stopTest();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stopTest

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      errCount++;
      $display("[ERR] %0t timeout", $time);
      stopTest();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bus tasks are entered just after a rising edge
  task automatic axW(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aDone, wDone;
    aDone = 0;
    wDone = 0;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF;
    while (!(aDone && wDone)) begin
      @(posedge mclk);
      if (awready) begin aDone = 1; awvalid <= 1'b0; end
      if (wready) begin wDone = 1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axW

  task automatic axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axR

  task automatic doReset();
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask : doReset

  // counts cycles from io release to core release
  task automatic waitRun(input int d);
    int n;
    n = 0;
    while (ioResetN !== 1'b1) @(posedge mclk);
    while (coreResetN !== 1'b1) begin @(posedge mclk); n++; end
    chk(32'(n >= d && n <= d + 3), 1);
  endtask : waitRun

  task automatic tStretch();
    for (int i = 0; i < 5; i++) begin
      fuse.startupTime <= 2'(i);
      fuse.clockSource <= (i == 4) ? 4'h1 : 4'h0;
      doReset();
      waitRun(DLY[i % 4] + ((i == 4) ? OSC_WARM_CYC : 0));
    end
    fuse.clockSource <= 4'h0;
    $display("done stretch");
  endtask : tStretch

  task automatic tSources();
    logic [31:0] d;
    logic [1:0]  r;
    for (int s = 0; s < 3; s++) begin
      {brownReq, pinReq, porReq} <= 3'(1 << s);
      #1 if (s < 2) chk(32'(ioResetN), 0);
      repeat (60) @(posedge mclk);
      chk(32'({ioResetN, coreResetN}), 0);
      {brownReq, pinReq, porReq} <= 3'h0;
      waitRun(DLY[0]);
      axR(ADDR_STATUS, d, r);
      chk(d, 32'(1 << s));
      axW(ADDR_STATUS, 32'h0, r);
    end
    $display("done sources");
  endtask : tSources

  task automatic tFilter();
    brownReq <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(32'(ioResetN), 1);
    brownReq <= 1'b0;
    pinResetEnable <= 1'b0;
    pinReq <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(32'(ioResetN), 1);
    pinReq <= 1'b0;
    repeat (8) @(posedge mclk);
    pinResetEnable <= 1'b1;
    $display("done filter");
  endtask : tFilter

  task automatic tWdog();
    logic [31:0] d;
    logic [1:0]  r;
    axR(ADDR_WDOG, d, r); chk(d, 32'h00);
    axW(ADDR_WDOG, 32'h08, r);
    axW(ADDR_WDOG, 32'h00, r); axR(ADDR_WDOG, d, r); chk(d, 32'h08);
    axW(ADDR_WDOG, 32'h18, r); axR(ADDR_WDOG, d, r); chk(d, 32'h18);
    repeat (8) @(posedge mclk);
    axR(ADDR_WDOG, d, r); chk(d, 32'h08);
    axW(ADDR_WDOG, 32'h18, r); axW(ADDR_WDOG, 32'h00, r);
    axW(ADDR_WDOG, 32'h21, r); axR(ADDR_WDOG, d, r); chk(d, 32'h21);
    axW(ADDR_WDOG, 32'h00, r);
    axW(ADDR_RESTART, 32'h1, r); axR(ADDR_RESTART, d, r); chk(d, 32'h0);
    axW(8'h10, 32'h1, r); chk(32'(r), 32'(RESP_SLVERR));
    axR(8'h10, d, r); chk({d[29:0], r}, 32'(RESP_SLVERR));
    fuse.watchdogAlwaysOn <= 1'b1;
    doReset();
    axR(ADDR_WDOG, d, r); chk(d, 32'h08);
    axW(ADDR_WDOG, 32'h05, r); axR(ADDR_WDOG, d, r); chk(d, 32'h08);
    axW(ADDR_WDOG, 32'h18, r); axW(ADDR_WDOG, 32'h05, r);
    axR(ADDR_WDOG, d, r); chk(d, 32'h0D);
    fuse.watchdogAlwaysOn <= 1'b0;
    doReset();
    $display("done watchdog");
  endtask : tWdog

  task automatic tAnalog();
    logic [31:0] d;
    logic [1:0]  r;
    fuse.brownoutLevel <= BROWNOUT_OFF;
    for (int i = 0; i < 4; i++) begin
      axW(ADDR_ANALOG, 32'(i), r);
      axR(ADDR_ANALOG, d, r);
      chk(d, 32'(i) | ((i != 0) ? 32'h100 : 32'h0));
      chk(32'(refEnable), 32'(i != 0));
    end
    fuse.brownoutLevel <= 3'h3;
    $display("done analog");
  endtask : tAnalog

  task automatic tExpiry();
    logic [31:0] d;
    logic [1:0]  r;
    axW(ADDR_WDOG, 32'h48, r);
    repeat (1500) @(posedge mclk);
    axW(ADDR_RESTART, 32'h1, r);
    repeat (1500) @(posedge mclk);
    chk(32'(watchdogIrq), 0);
    while (watchdogWake !== 1'b1) @(posedge mclk);
    axR(ADDR_WDOG, d, r);
    chk(d, 32'h88);
    chk(32'(watchdogIrq), 1);
    while (ioResetN !== 1'b0) @(posedge mclk);
    waitRun(DLY[0]);
    axR(ADDR_STATUS, d, r);
    chk(d, 32'h08);
    axR(ADDR_WDOG, d, r);
    chk(d, 32'h08);
    axW(ADDR_STATUS, 32'h0, r);
    axR(ADDR_WDOG, d, r);
    chk(d, 32'h00);
    $display("done expiry");
  endtask : tExpiry

  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    tStretch();
    tSources();
    tFilter();
    tWdog();
    tAnalog();
    tExpiry();
    stopTest();
  end
endmodule : tb
